// ==== rtl/dcc_clock_config.sv ====
// dithered clock configuration, nv write policy and output control
`timescale 1ns/100ps
`include "dcc_regs.svh"
module dcc_clock_config import dcc_pkg::*; (
    // clocks and reset
    input  logic            ref_clk,
    input  logic            osc_clk,
    input  logic            rst_n,
    // i2c pins
    input  logic            scl_i,
    input  logic            sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // control pins
    input  logic            power_down_pin_n,
    input  logic            out_gate_pin,
    input  logic            spread_pin,
    // nonvolatile store
    input  logic [7:0]      nv_div_in,
    input  logic [7:0]      nv_span_in,
    output dcc_nv_wr_type   nv_wr,
    // oscillator control
    output logic            osc_run,
    output logic            dither_active,
    output logic [7:0]      dither_trim,
    output logic [1:0]      dither_span_sel,
    // clock output pin
    output logic            clk_out_o,
    output logic            clk_out_oe
);
    typedef struct packed {
        logic [1:0]    pdn_s;
        logic          osc_run;
        logic          loaded;
        logic [7:0]    div;
        logic [7:0]    span;
        logic          pend_div;
        logic          pend_span;
        dcc_nv_wr_type nv;
        dcc_cfg_type   xfer;
        logic          sent;
        logic          req;
        logic [1:0]    ack_s;
    } dcc_ref_st_type;
    typedef struct packed {
        logic [2:0]    req_s;
        logic          ack;
        logic          cfg_ok;
        dcc_cfg_type   cfg;
        logic [1:0]    pdn_s;
        logic [1:0]    gate_s;
        logic [1:0]    spr_s;
        logic [10:0]   start_cnt;
        logic          started;
        logic [8:0]    cnt;
        logic          drive_en;
        logic          out;
        logic          oe;
        logic [13:0]   phase;
        logic          dith_act;
        logic [7:0]    trim;
    } dcc_osc_st_type;

    dcc_ref_st_type  r;
    dcc_ref_st_type  next_r;
    dcc_osc_st_type  o;
    dcc_osc_st_type  next_o;
    dcc_bus_evt_type bus;
    logic [7:0]      rd_addr;
    logic [7:0]      rd_data;
    logic            fl_div;
    logic            fl_span;
    logic [3:0]      expo;
    logic [8:0]      wmask;
    logic [8:0]      cnt_inc;
    logic            want;
    logic [1:0]      rate;
    logic [13:0]     pmask;
    logic [13:0]     pshift;
    logic [6:0]      tri_mag;
    logic [7:0]      offs;

    // =========================================================
    // serial port
    // =========================================================
    dcc_i2c_slave u_slave (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .addr_low (r.span[`DCC_ADDR_HI:`DCC_ADDR_LO]),
        .rd_data  (rd_data),
        .rd_addr  (rd_addr),
        .evt      (bus)
    );

    // read mux, unmapped pointers read zero
    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == `DCC_DIV_OFS) begin
            rd_data = r.div;
        end else if (rd_addr == `DCC_SPAN_OFS) begin
            rd_data = r.span;
        end
    end

    // =========================================================
    // register domain
    // =========================================================
    // registers, nv write policy and config handoff
    always_comb begin
        next_r = r;
        next_r.nv.wr = 1'b0;
        next_r.nv.div = 1'b0;
        next_r.nv.span = 1'b0;
        next_r.pdn_s = {r.pdn_s[0], power_down_pin_n};
        next_r.osc_run = r.pdn_s[1];
        next_r.ack_s = {r.ack_s[0], o.ack};
        fl_div = 1'b0;
        fl_span = 1'b0;
        if (!r.loaded) begin
            next_r.div = nv_div_in;
            next_r.span = nv_span_in;
            next_r.loaded = 1'b1;
        end else if (bus.wr) begin
            if (bus.addr == `DCC_DIV_OFS) begin
                next_r.div = bus.data;
                next_r.pend_div = 1'b1;
            end
            if (bus.addr == `DCC_SPAN_OFS) begin
                next_r.span = bus.data;
                next_r.pend_span = 1'b1;
            end
        end else if (bus.stop) begin
            fl_span = r.pend_span || bus.commit;
            fl_div = (r.pend_div && !r.span[`DCC_DEFER]) ||
                     bus.commit;
            next_r.pend_div = 1'b0;
            next_r.pend_span = 1'b0;
            if (fl_div || fl_span) begin
                next_r.nv.wr = 1'b1;
                next_r.nv.div = fl_div;
                next_r.nv.span = fl_span;
                next_r.nv.div_data = r.div;
                next_r.nv.span_data = r.span;
            end
        end
        // toggle handshake, word held until acknowledged
        if (r.loaded && (r.req == r.ack_s[1]) &&
            (!r.sent || r.xfer != {r.div, r.span})) begin
            next_r.xfer = {r.div, r.span};
            next_r.req = ~r.req;
            next_r.sent = 1'b1;
        end
    end

    // register domain state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{div: `DCC_DIV_RESET, span: `DCC_SPAN_RESET,
                   default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign nv_wr   = r.nv;
    assign osc_run = r.osc_run;

    // =========================================================
    // oscillator domain
    // =========================================================
    // config capture, startup, divider, gating and dither
    always_comb begin
        next_o = o;
        next_o.req_s = {o.req_s[1:0], r.req};
        next_o.pdn_s = {o.pdn_s[0], power_down_pin_n};
        next_o.gate_s = {o.gate_s[0], out_gate_pin};
        next_o.spr_s = {o.spr_s[0], spread_pin};
        if (o.req_s[2] != o.req_s[1]) begin
            next_o.cfg = r.xfer;
            next_o.ack = o.req_s[1];
            next_o.cfg_ok = 1'b1;
        end
        // power-up hold-off
        if (!o.started) begin
            next_o.start_cnt = o.start_cnt + 11'h001;
            next_o.started = (o.start_cnt ==
                11'(`DCC_STARTUP_EDGES - 1));
        end
        expo = next_o.cfg.div[`DCC_EXP_HI:`DCC_EXP_LO];
        if (expo > `DCC_EXP_MAX) begin
            expo = `DCC_EXP_MAX;
        end
        wmask = 9'h1ff >> (4'h8 - expo);
        cnt_inc = (o.cnt + 9'h001) & wmask;
        want = o.started && next_o.cfg_ok && o.pdn_s[1] &&
               (!next_o.cfg.span[`DCC_GATE_N] || o.gate_s[1]);
        if (!o.drive_en) begin
            next_o.cnt = 9'h000;
            next_o.drive_en = want;
        end else if (!want && cnt_inc == 9'h000) begin
            next_o.cnt = 9'h000;
            next_o.drive_en = 1'b0;
        end else begin
            next_o.cnt = cnt_inc;
        end
        next_o.out = next_o.drive_en && next_o.cnt[expo];
        next_o.oe = next_o.drive_en ||
                    next_o.cfg.div[`DCC_PD_LOW];
        // triangle dither, period set by the rate select
        rate = next_o.cfg.div[`DCC_RATE_HI:`DCC_RATE_LO];
        next_o.dith_act = next_o.cfg_ok && (rate != 2'b00) &&
                          o.spr_s[1];
        pmask = 14'h3fff >> (2'd3 - rate);
        if (!next_o.dith_act) begin
            next_o.phase = 14'h0000;
        end else begin
            next_o.phase = (o.phase + 14'h0001) & pmask;
        end
        pshift = next_o.phase >> ((rate == 2'b00) ? 2'd0 : rate - 2'd1);
        tri_mag = pshift[11] ? ~pshift[10:4] : pshift[10:4];
        offs = {1'b0, tri_mag} - 8'h40;
        if (next_o.dith_act) begin
            next_o.trim = 8'($signed(offs) >>>
                (2'd3 - next_o.cfg.span[`DCC_SPAN_HI:`DCC_SPAN_LO]));
        end else begin
            next_o.trim = 8'h00;
        end
    end

    // oscillator domain state
    always_ff @(posedge osc_clk or negedge rst_n) begin
        if (!rst_n) begin
            o <= '0;
        end else begin
            o <= next_o;
        end
    end

    assign clk_out_o       = o.out;
    assign clk_out_oe      = o.oe;
    assign dither_active   = o.dith_act;
    assign dither_trim     = o.trim;
    assign dither_span_sel = o.cfg.span[`DCC_SPAN_HI:`DCC_SPAN_LO];

    // =========================================================
    // checks
    // =========================================================
    rate_period_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        (o.cfg.div[7:6] == 2'b01) |-> (o.phase < 14'h1000))
        else $error("dither phase beyond shortest period");
    dither_gate_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        o.dith_act |-> ($past(o.spr_s[1]) && o.cfg.div[7:6] != 2'b00))
        else $error("dither active without spread and rate");
    span_range_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        (o.cfg.span[7:6] == 2'b00) |->
        ($signed(o.trim) >= -8 && $signed(o.trim) <= 7))
        else $error("smallest span exceeded");
    quiet_trim_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        !o.dith_act |-> (o.trim == 8'h00))
        else $error("trim moves while dither off");
    pd_level_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        !o.drive_en |-> (o.cfg.div[5] ? (o.oe && !o.out) : !o.oe))
        else $error("disabled output level wrong");
    exp_clamp_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        (o.drive_en && o.cfg.div[3:0] >= 4'h8 && o.cnt < 9'h100)
        |-> !o.out)
        else $error("exponent not clamped to eight");
    enable_sync_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        (!$past(o.drive_en) && o.drive_en) |-> (o.cnt == 9'h000 &&
        !o.out && $past(o.pdn_s[1]) &&
        (!o.cfg.span[5] || $past(o.gate_s[1]))))
        else $error("output enabled off boundary or gate");
    startup_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
        o.drive_en |-> (o.start_cnt == 11'(`DCC_STARTUP_EDGES)))
        else $error("output before startup count");
    osc_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !r.pdn_s[1] |=> !r.osc_run)
        else $error("oscillator runs in power down");
    defer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.nv.wr && r.nv.div) |->
        ($past(!r.span[`DCC_DEFER]) || $past(bus.commit)))
        else $error("deferred divider reached nv");
    span_flush_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus.stop && r.pend_span) |=> (r.nv.wr && r.nv.span))
        else $error("span write not flushed");
    commit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bus.commit |=> (r.nv.wr && r.nv.div && r.nv.span))
        else $error("commit did not write all");
    after_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        r.nv.wr |-> $past(bus.stop))
        else $error("nv write before stop");
    reg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus.wr && bus.addr == `DCC_DIV_OFS && r.loaded) |=>
        (r.div == $past(bus.data)))
        else $error("divider register not updated");
endmodule : dcc_clock_config

// ==== rtl/dcc_regs.svh ====
// register offsets, field positions, reset values and counts
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_DIV_OFS      8'h02
`define DCC_SPAN_OFS     8'h0D
`define DCC_COMMIT_OFS   8'h3F
`define DCC_DIV_RESET    8'h00
`define DCC_SPAN_RESET   8'h00
`define DCC_RATE_HI      7
`define DCC_RATE_LO      6
`define DCC_PD_LOW       5
`define DCC_EXP_HI       3
`define DCC_EXP_LO       0
`define DCC_SPAN_HI      7
`define DCC_SPAN_LO      6
`define DCC_GATE_N       5
`define DCC_DEFER        3
`define DCC_ADDR_HI      2
`define DCC_ADDR_LO      0
`define DCC_EXP_MAX      4'h8
`define DCC_ADDR_HIGH    4'hA
`define DCC_STARTUP_CYC  512
`define DCC_LINK_PER_MC  2
`define DCC_STARTUP_EDGES (`DCC_STARTUP_CYC * `DCC_LINK_PER_MC)
`endif

// ==== rtl/dcc_pkg.sv ====
// types shared by the clock configuration block
package dcc_pkg;
    typedef enum logic [8:0] {
        I2C_IDLE  = 9'h001, I2C_ADDR  = 9'h002, I2C_AACK  = 9'h004,
        I2C_PTR   = 9'h008, I2C_PACK  = 9'h010, I2C_WDATA = 9'h020,
        I2C_WACK  = 9'h040, I2C_RDATA = 9'h080, I2C_RACK  = 9'h100
    } dcc_i2c_state_type;
    typedef struct packed {
        logic [7:0] div;
        logic [7:0] span;
    } dcc_cfg_type;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic       stop;
        logic       commit;
    } dcc_bus_evt_type;
    typedef struct packed {
        logic       wr;
        logic       div;
        logic       span;
        logic [7:0] div_data;
        logic [7:0] span_data;
    } dcc_nv_wr_type;
    typedef struct packed {
        dcc_i2c_state_type st;
        logic [1:0]        scl_s;
        logic [1:0]        sda_s;
        logic              scl_q;
        logic              sda_q;
        logic [3:0]        cnt;
        logic [7:0]        sh;
        logic [7:0]        ptr;
        logic              rd;
        logic              nack;
        logic              got_ptr;
        logic              got_data;
        logic              oe;
        dcc_bus_evt_type   evt;
    } dcc_slv_st_type;
endpackage : dcc_pkg

// ==== rtl/dcc_i2c_slave.sv ====
// i2c register-access slave for the clock configuration block
`timescale 1ns/100ps
`include "dcc_regs.svh"
module dcc_i2c_slave import dcc_pkg::*; (
    // clock and reset
    input  logic            ref_clk,
    input  logic            rst_n,
    // i2c pins
    input  logic            scl_i,
    input  logic            sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // register side
    input  logic [2:0]      addr_low,
    input  logic [7:0]      rd_data,
    output logic [7:0]      rd_addr,
    output dcc_bus_evt_type evt
);
    dcc_slv_st_type s;
    dcc_slv_st_type next_s;
    logic           scl;
    logic           sda;

    // =========================================================
    // bus decoding
    // =========================================================
    // start, stop, bit shifting and acknowledge on scl edges
    always_comb begin
        next_s = s;
        next_s.scl_s = {s.scl_s[0], scl_i};
        next_s.sda_s = {s.sda_s[0], sda_i};
        scl = s.scl_s[1];
        sda = s.sda_s[1];
        next_s.scl_q = scl;
        next_s.sda_q = sda;
        next_s.evt.wr = 1'b0;
        next_s.evt.stop = 1'b0;
        next_s.evt.commit = 1'b0;
        if (scl && s.scl_q && s.sda_q && !sda) begin
            next_s.st = I2C_ADDR;
            next_s.cnt = 4'h0;
            next_s.oe = 1'b0;
            next_s.got_ptr = 1'b0;
            next_s.got_data = 1'b0;
        end else if (scl && s.scl_q && !s.sda_q && sda) begin
            next_s.st = I2C_IDLE;
            next_s.oe = 1'b0;
            next_s.evt.stop = 1'b1;
            next_s.evt.commit = s.got_ptr && !s.got_data &&
                                (s.ptr == `DCC_COMMIT_OFS);
        end else if (scl && !s.scl_q) begin
            next_s.cnt = s.cnt + 4'h1;
            if (s.st != I2C_RDATA) begin
                next_s.sh = {s.sh[6:0], sda};
            end
            if (s.st == I2C_RACK) begin
                next_s.nack = sda;
            end
        end else if (!scl && s.scl_q) begin
            unique case (s.st)
                I2C_IDLE: begin
                end
                I2C_ADDR: begin
                    if (s.cnt == 4'h8) begin
                        if (s.sh[7:1] == {`DCC_ADDR_HIGH, addr_low}) begin
                            next_s.oe = 1'b1;
                            next_s.rd = s.sh[0];
                            next_s.st = I2C_AACK;
                        end else begin
                            next_s.st = I2C_IDLE;
                        end
                    end
                end
                I2C_AACK: begin
                    next_s.cnt = 4'h0;
                    if (s.rd) begin
                        next_s.st = I2C_RDATA;
                        next_s.sh = rd_data;
                        next_s.oe = ~rd_data[7];
                    end else begin
                        next_s.oe = 1'b0;
                        next_s.st = I2C_PTR;
                    end
                end
                I2C_PTR: begin
                    if (s.cnt == 4'h8) begin
                        next_s.ptr = s.sh;
                        next_s.got_ptr = 1'b1;
                        next_s.oe = 1'b1;
                        next_s.st = I2C_PACK;
                    end
                end
                I2C_PACK, I2C_WACK: begin
                    next_s.oe = 1'b0;
                    next_s.cnt = 4'h0;
                    next_s.st = I2C_WDATA;
                end
                I2C_WDATA: begin
                    if (s.cnt == 4'h8) begin
                        next_s.evt.wr = 1'b1;
                        next_s.evt.addr = s.ptr;
                        next_s.evt.data = s.sh;
                        next_s.got_data = 1'b1;
                        next_s.oe = 1'b1;
                        next_s.st = I2C_WACK;
                    end
                end
                I2C_RDATA: begin
                    if (s.cnt == 4'h8) begin
                        next_s.oe = 1'b0;
                        next_s.st = I2C_RACK;
                    end else begin
                        next_s.sh = {s.sh[6:0], 1'b0};
                        next_s.oe = ~s.sh[6];
                    end
                end
                I2C_RACK: begin
                    next_s.cnt = 4'h0;
                    if (s.nack) begin
                        next_s.oe = 1'b0;
                        next_s.st = I2C_IDLE;
                    end else begin
                        next_s.sh = rd_data;
                        next_s.oe = ~rd_data[7];
                        next_s.st = I2C_RDATA;
                    end
                end
                default: begin
                    next_s.st = I2C_IDLE;
                    next_s.oe = 1'b0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{st: I2C_IDLE, scl_s: 2'h3, sda_s: 2'h3, scl_q: 1'b1,
                   sda_q: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign sda_o   = 1'b0;
    assign sda_oe  = s.oe;
    assign rd_addr = s.ptr;
    assign evt     = s.evt;

    // acknowledge only a matching slave address
    addr_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == I2C_ADDR && next_s.st == I2C_AACK) |=>
        (s.oe && $past(s.sh[3:1]) == addr_low))
        else $error("ack given to foreign address");
endmodule : dcc_i2c_slave

// ==== dv/dcc_i2c_master.sv ====
// i2c bus controller model for the clock configuration block
`timescale 1ns/100ps
module dcc_i2c_master (
    // bus clock
    input  wire logic ref_clk,
    // i2c wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_dn
);
    // ==========
    // bus primitives
    // idle bus: scl high, sda released to the pull-up
    initial begin
        scl = 1'b1;
        sda_dn = 1'b0;
    end
    // a third of an scl period, changes land just after an edge
    task automatic hp();
        repeat (10) @(posedge ref_clk);
        #1;
    endtask : hp
    // start from idle
    task automatic start();
        hp();
        sda_dn = 1'b1;
        hp();
        scl = 1'b0;
        hp();
    endtask : start
    // stop ends the transaction
    task automatic stop();
        sda_dn = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_dn = 1'b0;
        hp();
    endtask : stop
    // one bit, sampled while scl is high
    task automatic bit_x(input logic b, output logic r);
        sda_dn = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
        hp();
    endtask : bit_x
    // msb-first byte then the ninth bit; last=1 releases it
    task automatic xfer(input logic [7:0] w, input logic last,
                        output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_x(w[i], b);
            r[i] = b;
        end
        bit_x(last, b);
        ack = !b;
    endtask : xfer
endmodule : dcc_i2c_master

// ==== dv/dithered_clock_config_test.sv ====
// self-checking bench of the dithered clock configuration block
`timescale 1ns/100ps
`include "dcc_regs.svh"
module dithered_clock_config_test import dcc_pkg::*; ;
    // ==========
    // signals and instances
    logic          ref_clk, osc_clk, rst_n, scl, sda, sda_dn, sda_o;
    logic          sda_oe, pdn_n, gate, spread, osc_run, dact;
    logic          clk_out_o, clk_out_oe;
    logic [7:0]    nv_div_in, nv_span_in, trim;
    logic [1:0]    span_sel;
    logic [2:0]    alow;
    logic [31:0]   seed = 32'h0000_005A;
    dcc_nv_wr_type nv_wr, nv_last;
    int            n_mismatch, checks, nv_n, n0;
    // open-drain wire with pull-up
    assign sda = !(sda_oe | sda_dn);
    dcc_i2c_master M (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_dn(sda_dn));
    dcc_clock_config DUT (.ref_clk(ref_clk), .osc_clk(osc_clk),
        .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .power_down_pin_n(pdn_n), .out_gate_pin(gate),
        .spread_pin(spread), .nv_div_in(nv_div_in),
        .nv_span_in(nv_span_in), .nv_wr(nv_wr), .osc_run(osc_run),
        .dither_active(dact), .dither_trim(trim),
        .dither_span_sel(span_sel), .clk_out_o(clk_out_o),
        .clk_out_oe(clk_out_oe));
    // two unrelated clocks
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        osc_clk = 1'b0;
        #7;
        forever #24 osc_clk = ~osc_clk;
    end
    // nv write monitor
    always @(posedge ref_clk) begin
        if (nv_wr.wr === 1'b1) begin
            nv_n++;
            nv_last = nv_wr;
        end
    end
    // ==========
    // helpers
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH at %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // register write; nodat sends only the pointer
    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      input logic nodat, output logic ak);
        logic [7:0] r;
        logic       a2;
        n0 = nv_n;
        M.start();
        M.xfer({`DCC_ADDR_HIGH, alow, 1'b0}, 1'b1, r, ak);
        M.xfer(p, 1'b1, r, a2);
        if (!nodat) M.xfer(d, 1'b1, r, a2);
        repeat (20) @(posedge ref_clk);
        cmp(16'(nv_n - n0), 16'h0000);
        M.stop();
        repeat (20) @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic a;
        wr(p, 8'h00, 1'b1, a);
        M.start();
        M.xfer({`DCC_ADDR_HIGH, alow, 1'b1}, 1'b1, d, a);
        M.xfer(8'hFF, 1'b1, d, a);
        M.stop();
    endtask : rd
    // osc edges between the second and third output rise
    task automatic per(output int n);
        logic p;
        int   c;
        p = 1'b1;
        c = 0;
        n = 0;
        for (int k = 0; k < 4000 && c < 3; k++) begin
            @(posedge osc_clk);
            #1;
            n++;
            if (clk_out_o === 1'b1 && p === 1'b0) begin
                c++;
                if (c < 3) n = 0;
            end
            p = clk_out_o;
        end
        if (c < 3) begin
            n_mismatch++;
            conclude();
        end
    endtask : per
    // ==========
    // main sequence
    initial begin
        logic [7:0] d;
        logic [3:0] e;
        logic [7:0] q;
        logic       a;
        int         n;
        rst_n = 1'b0;
        pdn_n = 1'b1;
        gate = 1'b0;
        spread = 1'b0;
        nv_div_in = 8'h01;
        nv_span_in = 8'h00;
        alow = 3'h0;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        // startup hold, then nv divider in force
        repeat (1000) @(posedge osc_clk);
        #1;
        cmp(clk_out_oe, 1'b0);
        cmp(sda_o, 1'b0);
        per(n);
        cmp(n[15:0], 16'h0004);
        cmp(clk_out_oe, 1'b1);
        $display("test startup done");
        // random divider writes with corner exponents
        for (int i = 0; i < 6; i++) begin
            d = rnd();
            if (i < 3) d[3:0] = (i == 0) ? 4'h0 : ((i == 1) ? 4'h8 : 4'hF);
            if (i == 3) d[7:4] = 4'h5;
            spread = d[4];
            wr(8'h02, d, 1'b0, a);
            cmp(a, 1'b1);
            cmp(16'(nv_n - n0), 16'h0001);
            cmp(nv_last[17:8], {2'b10, d});
            rd(8'h02, q);
            cmp(q, d);
            e = (d[3:0] > `DCC_EXP_MAX) ? `DCC_EXP_MAX : d[3:0];
            per(n);
            cmp(n[15:0], 16'(2 << e));
            cmp(dact, (|d[7:6]) & d[4]);
            // smallest span keeps the trim within -8..7, idle trim is 0
            a = dact ? ($signed(trim) >= -8 && $signed(trim) <= 7)
                     : (trim == 8'h00);
            cmp(a, 1'b1);
        end
        $display("test divider done");
        // span write with defer, deferred divider, commit
        wr(8'h0D, 8'h6D, 1'b0, a);
        cmp(16'(nv_n - n0), 16'h0001);
        cmp({nv_last.span, nv_last.span_data}, {1'b1, 8'h6D});
        cmp(span_sel, 2'b01);
        alow = 3'h5;
        wr(8'h02, 8'h00, 1'b0, a);
        cmp(16'(nv_n - n0), 16'h0000);
        wr(8'h3F, 8'h00, 1'b1, a);
        cmp(16'(nv_n - n0), 16'h0001);
        cmp(nv_last[17:8], {2'b11, 8'h00});
        alow = 3'h0;
        wr(8'h02, 8'h00, 1'b0, a);
        cmp(a, 1'b0);
        alow = 3'h5;
        $display("test nv policy done");
        // pin combinations with the gate bit set
        for (int i = 3; i >= 0; i--) begin
            @(posedge ref_clk);
            #1;
            pdn_n = i[1];
            gate = i[0];
            repeat (100) @(posedge ref_clk);
            cmp(osc_run, i[1]);
            cmp(clk_out_oe, i[1] & i[0]);
        end
        wr(8'h02, 8'h20, 1'b0, a);
        cmp({clk_out_oe, clk_out_o}, 2'b10);
        $display("test output control done");
        conclude();
    end
endmodule : dithered_clock_config_test
